// ==== inc/pcb_pkg.sv ====
/*
  pcb_pkg: register map, field positions, reset values and carrier types of
  the coding-path, self-test and indicator control register bank.
  Assumes a 16-bit register port addressed by register index.
*/
`default_nettype none
package pcb_pkg;
  // ****************************************
  // register indexes
  // ****************************************
  localparam logic [4:0] ADDR_CODING = 5'h16;
  localparam logic [4:0] ADDR_RSVD_A = 5'h17;
  localparam logic [4:0] ADDR_RSVD_B = 5'h18;
  localparam logic [4:0] ADDR_SELFTEST = 5'h19;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h1a;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h1b;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h1c;

  // ****************************************
  // coding configuration fields
  // ****************************************
  localparam int CODING_BLOCK_BYP = 12;
  localparam int CODING_FREE_CLK = 11;
  localparam int CODING_QUIET = 10;
  localparam int CODING_SD_FORCE = 9;
  localparam int CODING_SD_ALG = 8;
  localparam int CODING_FORCE_LINK = 5;
  localparam int CODING_NRZI_BYP = 2;
  localparam int CODING_SCRAM_BYP = 1;
  localparam int CODING_DESCRAM_BYP = 0;
  localparam logic [15:0] CODING_RESET = 16'h0100;
  // writable bits: 12..8, 5, 2..0; 15:13, 7, 6, 4, 3 read zero
  localparam logic [15:0] CODING_WMASK = 16'h1f27;

  // ****************************************
  // self-test / indicator / address fields
  // ****************************************
  localparam int ST_SEQ_SEL = 11;
  localparam int ST_RESULT = 10;
  localparam int ST_RUN = 9;
  localparam int ST_STRETCH_BYP = 8;
  localparam int ST_PAUSE = 7;
  localparam int ST_FIXED_ONE = 6;
  localparam int ST_LED_POL = 5;
  localparam int ST_ADDR_LSB = 0;
  localparam int ST_ADDR_W = 5;
  localparam logic [4:0] ADDR_RESET = 5'h00;

  // ****************************************
  // interrupt event bits
  // ****************************************
  localparam int IRQ_W = 3;
  localparam int IRQ_ST_FAIL = 0;
  localparam int IRQ_ST_DONE = 1;
  localparam int IRQ_PAUSE_CHG = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pcb_req_type;

  typedef struct packed {
    logic block_code_bypass;
    logic free_clock;
    logic quiet_transmit_enable;
    logic signal_detect_force;
    logic signal_detect_algorithm_select;
    logic force_link_100;
    logic nrzi_bypass;
    logic transmit_scrambler_bypass;
    logic receive_descrambler_bypass;
  } pcb_coding_type;

  typedef struct packed {
    logic selftest_run;
    logic long_prbs_sequence;
    logic short_prbs_sequence;
    logic indicator_stretch_bypass;
    logic indicator_polarity_config;
    logic [4:0] port_address;
  } pcb_ctrl_type;
endpackage : pcb_pkg
`default_nettype wire

// ==== rtl/pcb_regs.sv ====
/*
  pcb_regs: coding-path configuration, self-test control/result, indicator
  and port address register bank with interrupt status/enable/clear.
  Assumes a synchronous register port on mclk and strap pins from outside,
  which pass two flops; the datapaths report their status synchronously.
*/
`timescale 1ns/10ps
`default_nettype none
module pcb_regs
  import pcb_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire pcb_pkg::pcb_req_type req,
  output logic [15:0] rdata,
  input wire logic selftest_error,
  input wire logic selftest_done,
  input wire logic local_pause_adv,
  input wire logic partner_pause_adv,
  input wire logic link_100_raw,
  input wire logic duplex_raw,
  input wire logic rx_act_raw,
  input wire logic tx_act_raw,
  input wire logic col_act_raw,
  input wire logic rx_act_stretched,
  input wire logic tx_act_stretched,
  input wire logic col_act_stretched,
  input wire logic strap_led_pol,
  input wire logic [4:0] strap_port_address,
  output pcb_pkg::pcb_coding_type coding,
  output pcb_pkg::pcb_ctrl_type ctrl,
  output logic link_100_ok,
  output logic duplex_indicator,
  output logic rx_indicator,
  output logic tx_indicator,
  output logic col_indicator,
  output logic irq
);
  import pcb_pkg::*;

  function automatic logic hit(input pcb_req_type r, input logic [4:0] a);
    hit = r.addr == a;
  endfunction : hit

  // ****************************************
  // strap synchronisers and capture
  // ****************************************
  logic [5:0] strap_meta;
  logic [5:0] strap_sync;
  logic strap_taken;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_meta <= 6'h00;
      strap_sync <= 6'h00;
    end
    else
    begin
      strap_meta <= {strap_led_pol, strap_port_address};
      strap_sync <= strap_meta;
    end
  end

  // ****************************************
  // coding configuration register
  // ****************************************
  logic [15:0] coding_reg;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      coding_reg <= CODING_RESET;
    else if (req.wr && hit(req, ADDR_CODING))
      coding_reg <= req.wdata & CODING_WMASK;
  end

  // ****************************************
  // coding outputs
  // ****************************************
  always_comb
  begin
    coding.block_code_bypass = coding_reg[CODING_BLOCK_BYP];
    coding.free_clock = coding_reg[CODING_FREE_CLK];
    coding.quiet_transmit_enable = coding_reg[CODING_QUIET];
    coding.signal_detect_force = coding_reg[CODING_SD_FORCE];
    coding.signal_detect_algorithm_select = coding_reg[CODING_SD_ALG];
    coding.force_link_100 = coding_reg[CODING_FORCE_LINK];
    coding.nrzi_bypass = coding_reg[CODING_NRZI_BYP];
    coding.transmit_scrambler_bypass = coding_reg[CODING_SCRAM_BYP];
    coding.receive_descrambler_bypass = coding_reg[CODING_DESCRAM_BYP];
  end

  // ****************************************
  // forced link
  // ****************************************
  // the link_100_ok output follows the forced value; no read-back status bit does
  assign link_100_ok = link_100_raw | coding_reg[CODING_FORCE_LINK];

  // ****************************************
  // reserved slots: plain storage, no reset
  // ****************************************
  // values undefined until written; software is expected not to touch them
  logic [15:0] rsvd_a;
  logic [15:0] rsvd_b;
  always_ff @(posedge mclk)
  begin
    if (req.wr && hit(req, ADDR_RSVD_A))
      rsvd_a <= req.wdata;
    if (req.wr && hit(req, ADDR_RSVD_B))
      rsvd_b <= req.wdata;
  end

  // ****************************************
  // self-test, indicator and address register
  // ****************************************
  logic seq_sel;
  logic run;
  logic stretch_byp;
  logic led_pol;
  logic [4:0] port_addr;
  logic result;
  logic pause_compare_result;
  logic st_wr;
  assign st_wr = req.wr && hit(req, ADDR_SELFTEST);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seq_sel <= 1'b0;
      run <= 1'b0;
      stretch_byp <= 1'b0;
    end
    else if (st_wr)
    begin
      seq_sel <= req.wdata[ST_SEQ_SEL];
      run <= req.wdata[ST_RUN];
      stretch_byp <= req.wdata[ST_STRETCH_BYP];
    end
  end

  // ****************************************
  // strap capture
  // ****************************************
  // the polarity and address bits of a software write in the first three cycles are lost to the strap load
  // straps are taken in the first cycle after their synchronisers settle
  logic [1:0] strap_wait;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      led_pol <= 1'b0;
      port_addr <= ADDR_RESET;
    end
    else if (!strap_taken)
    begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2)
      begin
        strap_taken <= 1'b1;
        led_pol <= strap_sync[5];
        port_addr <= strap_sync[4:0];
      end
    end
    else if (st_wr)
    begin
      led_pol <= req.wdata[ST_LED_POL];
      port_addr <= req.wdata[ST_ADDR_LSB +: ST_ADDR_W];
    end
  end

  // ****************************************
  // self-test result
  // ****************************************
  // fail latches low; any write to the self-test register re-arms it, an error
  // that same cycle still wins
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      result <= 1'b0;
    else if (run && selftest_error)
      result <= 1'b0;
    else if (st_wr)
      result <= 1'b1;
  end

  // ****************************************
  // pause compare
  // ****************************************
  // registered so a read sees one settled value for the whole cycle
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      pause_compare_result <= 1'b0;
    else
      pause_compare_result <= local_pause_adv & partner_pause_adv;
  end

  // ****************************************
  // control outputs
  // ****************************************
  always_comb
  begin
    ctrl.selftest_run = run;
    ctrl.long_prbs_sequence = run & seq_sel;
    ctrl.short_prbs_sequence = run & ~seq_sel;
    ctrl.indicator_stretch_bypass = stretch_byp;
    ctrl.indicator_polarity_config = led_pol;
    ctrl.port_address = port_addr;
  end

  // ****************************************
  // indicator outputs
  // ****************************************
  logic [3:0] ind_q;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      ind_q <= 4'h0;
    else
    begin
      ind_q[0] <= stretch_byp ? rx_act_raw : rx_act_stretched;
      ind_q[1] <= stretch_byp ? tx_act_raw : tx_act_stretched;
      ind_q[2] <= stretch_byp ? col_act_raw : col_act_stretched;
      // adjusted polarity drives the led active low
      ind_q[3] <= led_pol ? ~duplex_raw : duplex_raw;
    end
  end
  assign rx_indicator = ind_q[0];
  assign tx_indicator = ind_q[1];
  assign col_indicator = ind_q[2];
  assign duplex_indicator = ind_q[3];

  // ****************************************
  // interrupts
  // ****************************************
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [2:0] irq_event;
  logic pause_prev;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      pause_prev <= 1'b0;
    else
      pause_prev <= pause_compare_result;
  end

  assign irq_event[IRQ_ST_FAIL] = run & selftest_error;
  assign irq_event[IRQ_ST_DONE] = run & selftest_done;
  assign irq_event[IRQ_PAUSE_CHG] = pause_prev ^ pause_compare_result;

  genvar g;
  generate
    for (g = 0; g < IRQ_W; g++)
    begin : g_irq
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
          irq_status[g] <= 1'b0;
        // an event in the clear cycle wins so none is lost
        else if (irq_event[g])
          irq_status[g] <= 1'b1;
        else if (req.wr && hit(req, ADDR_IRQ_CLEAR) && req.wdata[g])
          irq_status[g] <= 1'b0;
      end
    end
  endgenerate

  // ****************************************
  // interrupt enable and output
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      irq_enable <= IRQ_RESET;
    else if (req.wr && hit(req, ADDR_IRQ_ENABLE))
      irq_enable <= req.wdata[IRQ_W-1:0];
  end
  assign irq = |(irq_status & irq_enable);

  // ****************************************
  // read port
  // ****************************************
  logic [15:0] next_rdata;
  always_comb
  begin
    next_rdata = 16'h0000;
    case (req.addr)
      ADDR_CODING: next_rdata = coding_reg;
      ADDR_RSVD_A: next_rdata = rsvd_a;
      ADDR_RSVD_B: next_rdata = rsvd_b;
      ADDR_SELFTEST:
      begin
        next_rdata[ST_SEQ_SEL] = seq_sel;
        next_rdata[ST_RESULT] = result;
        next_rdata[ST_RUN] = run;
        next_rdata[ST_STRETCH_BYP] = stretch_byp;
        next_rdata[ST_PAUSE] = pause_compare_result;
        next_rdata[ST_FIXED_ONE] = 1'b1;
        next_rdata[ST_LED_POL] = led_pol;
        next_rdata[ST_ADDR_LSB +: ST_ADDR_W] = port_addr;
      end
      ADDR_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
      ADDR_IRQ_ENABLE: next_rdata[IRQ_W-1:0] = irq_enable;
      default: next_rdata = 16'h0000;
    endcase
  end

  // ****************************************
  // read data register
  // ****************************************
  // zero outside the read cycle so a stale word never looks fresh
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= 16'h0000;
    else if (req.rd)
      rdata <= next_rdata;
    else
      rdata <= 16'h0000;
  end
endmodule : pcb_regs
`default_nettype wire

// ==== tb/pcb_regs_monitor.sv ====
/*
  pcb_regs_monitor: port assertions for the register bank.
  Assumes one clock, mclk, and the async active-low reset arst_n.
*/
`timescale 1ns/10ps
`default_nettype none
module pcb_regs_monitor
  import pcb_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire pcb_pkg::pcb_req_type req,
  input wire logic [15:0] rdata,
  input wire logic local_pause_adv,
  input wire logic partner_pause_adv,
  input wire logic link_100_raw,
  input wire logic duplex_raw,
  input wire logic [2:0] act_raw,
  input wire logic [2:0] act_str,
  input wire pcb_pkg::pcb_coding_type coding,
  input wire pcb_pkg::pcb_ctrl_type ctrl,
  input wire logic link_100_ok,
  input wire logic duplex_indicator,
  input wire logic [2:0] act_ind
);
  import pcb_pkg::*;
  default clocking mon_cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence coding_wr;
    req.wr && req.addr == ADDR_CODING;
  endsequence
  sequence coding_rd;
    req.rd && req.addr == ADDR_CODING;
  endsequence
  sequence pause_steady;
    ($stable(local_pause_adv) && $stable(partner_pause_adv))[*4];
  endsequence
  link_ok_a: assert property (
    link_100_ok == (link_100_raw | coding.force_link_100))
    else $error("forced link output wrong");
  prbs_pair_a: assert property (
    !(ctrl.long_prbs_sequence && ctrl.short_prbs_sequence) &&
    ((ctrl.long_prbs_sequence || ctrl.short_prbs_sequence) ==
     ctrl.selftest_run)) else $error("sequence selects inconsistent");
  coding_read_a: assert property (
    coding_rd |=> ((rdata & ~CODING_WMASK) == 16'h0))
    else $error("reserved coding bits read nonzero");
  coding_reset_a: assert property (
    $rose(arst_n) |-> coding == 9'h010)
    else $error("coding reset value wrong");
  coding_write_a: assert property (
    coding_wr |=> coding ==
      $past({req.wdata[12:8], req.wdata[5], req.wdata[2:0]}))
    else $error("coding write not applied");
  ctrl_write_a: assert property (
    $past(arst_n, 3) && req.wr && req.addr == ADDR_SELFTEST |=>
      {ctrl.selftest_run, ctrl.indicator_stretch_bypass,
       ctrl.indicator_polarity_config, ctrl.port_address} ==
      $past({req.wdata[9:8], req.wdata[5:0]}))
    else $error("control write not applied");
  pause_read_a: assert property (
    pause_steady ##0 (req.rd && req.addr == ADDR_SELFTEST) |=>
      rdata[ST_PAUSE] == $past(local_pause_adv & partner_pause_adv))
    else $error("pause status wrong");
  duplex_pol_a: assert property (
    $past(arst_n) |-> duplex_indicator == $past(duplex_raw ^
      ctrl.indicator_polarity_config)) else $error("duplex polarity wrong");
  stretch_sel_a: assert property (
    $past(arst_n) |-> act_ind == $past(ctrl.indicator_stretch_bypass ?
      act_raw : act_str)) else $error("indicator stretch select wrong");
endmodule : pcb_regs_monitor
bind pcb_regs pcb_regs_monitor pcb_regs_monitor_i (.mclk(mclk),
  .arst_n(arst_n), .req(req), .rdata(rdata),
  .local_pause_adv(local_pause_adv), .partner_pause_adv(partner_pause_adv),
  .link_100_raw(link_100_raw), .duplex_raw(duplex_raw),
  .act_raw({rx_act_raw, tx_act_raw, col_act_raw}),
  .act_str({rx_act_stretched, tx_act_stretched, col_act_stretched}),
  .coding(coding), .ctrl(ctrl), .link_100_ok(link_100_ok),
  .duplex_indicator(duplex_indicator),
  .act_ind({rx_indicator, tx_indicator, col_indicator}));
`default_nettype wire

// ==== tb/pcb_regs_test.sv ====
/*
  pcb_regs_test: register-port tests of coding, self-test, pause and irq.
  Assumes pcb_regs and the bound pcb_regs_monitor are compiled with it.
*/
`timescale 1ns/10ps
`default_nettype none
module pcb_regs_test;
  import pcb_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  pcb_req_type req = '0;
  logic [15:0] rdata;
  logic st_err = 1'b0, st_done = 1'b0, lpa = 1'b0, ppa = 1'b0;
  logic link_raw = 1'b0, dup_raw = 1'b1;
  logic [5:0] act = 6'h0;
  pcb_coding_type coding;
  pcb_ctrl_type ctrl;
  logic link_ok, dup_ind, rx_ind, tx_ind, col_ind, irq;
  logic [15:0] e;
  int fails = 0, total_checks = 0;
  always #20 mclk = ~mclk;
  pcb_regs pcb_regs_i (.mclk(mclk), .arst_n(arst_n), .req(req),
    .rdata(rdata), .selftest_error(st_err), .selftest_done(st_done),
    .local_pause_adv(lpa), .partner_pause_adv(ppa),
    .link_100_raw(link_raw), .duplex_raw(dup_raw), .rx_act_raw(act[5]),
    .tx_act_raw(act[4]), .col_act_raw(act[3]), .rx_act_stretched(act[2]),
    .tx_act_stretched(act[1]), .col_act_stretched(act[0]),
    .strap_led_pol(1'b1), .strap_port_address(5'h0b), .coding(coding),
    .ctrl(ctrl), .link_100_ok(link_ok), .duplex_indicator(dup_ind),
    .rx_indicator(rx_ind), .tx_indicator(tx_ind),
    .col_indicator(col_ind), .irq(irq));
  // ****************************************
  // port tasks
  // ****************************************
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check16
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr_reg
  // data stand only in the cycle after the strobe
  task automatic rd_check(input logic [4:0] a, input logic [15:0] exp);
    @(posedge mclk);
    req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 check16(rdata, exp);
  endtask : rd_check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    act <= 6'b101010;
    repeat (5) @(posedge mclk);
    rd_check(ADDR_CODING, 16'h0100);
    rd_check(ADDR_SELFTEST, 16'h006b);
    check16({12'h0, rx_ind, tx_ind, col_ind, dup_ind}, 16'h0004);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      e = (16'h0001 << i) & CODING_WMASK;
      wr_reg(ADDR_CODING, 16'h0001 << i);
      rd_check(ADDR_CODING, e);
      check16({7'h0, coding}, {7'h0, e[12:8], e[5], e[2:0]});
      check16({15'h0, link_ok}, {15'h0, e[5]});
    end
    // reserved slots 0x17 and 0x18 are never written by this bench
    rd_check(5'h1d, 16'h0000);
    rd_check(ADDR_IRQ_CLEAR, 16'h0000);
    $display("test coding done");
    wr_reg(ADDR_SELFTEST, 16'h0b2b);
    rd_check(ADDR_SELFTEST, 16'h0f6b);
    check16({15'h0, ctrl.long_prbs_sequence}, 16'h0001);
    wr_reg(ADDR_IRQ_ENABLE, 16'h0001);
    rd_check(ADDR_IRQ_ENABLE, 16'h0001);
    @(posedge mclk);
    st_err <= 1'b1;
    dup_raw <= 1'b0;
    @(posedge mclk);
    st_err <= 1'b0;
    rd_check(ADDR_SELFTEST, 16'h0b6b);
    check16({12'h0, rx_ind, tx_ind, col_ind, dup_ind}, 16'h000b);
    repeat (3) @(posedge mclk);
    rd_check(ADDR_SELFTEST, 16'h0b6b);
    rd_check(ADDR_IRQ_STATUS, 16'h0001);
    check16({15'h0, irq}, 16'h0001);
    wr_reg(ADDR_IRQ_CLEAR, 16'h0001);
    rd_check(ADDR_IRQ_STATUS, 16'h0000);
    check16({15'h0, irq}, 16'h0000);
    wr_reg(ADDR_SELFTEST, 16'h032b);
    rd_check(ADDR_SELFTEST, 16'h076b);
    check16({15'h0, ctrl.short_prbs_sequence}, 16'h0001);
    @(posedge mclk);
    st_done <= 1'b1;
    @(posedge mclk);
    st_done <= 1'b0;
    rd_check(ADDR_IRQ_STATUS, 16'h0002);
    check16({15'h0, irq}, 16'h0000);
    wr_reg(ADDR_SELFTEST, 16'h001f);
    rd_check(ADDR_SELFTEST, 16'h045f);
    $display("test selftest done");
    @(posedge mclk);
    lpa <= 1'b1;
    repeat (5) @(posedge mclk);
    rd_check(ADDR_SELFTEST, 16'h045f);
    ppa <= 1'b1;
    link_raw <= 1'b1;
    repeat (5) @(posedge mclk);
    rd_check(ADDR_SELFTEST, 16'h04df);
    check16({15'h0, link_ok}, 16'h0001);
    rd_check(ADDR_IRQ_STATUS, 16'h0006);
    wr_reg(ADDR_IRQ_CLEAR, 16'h0006);
    rd_check(ADDR_IRQ_STATUS, 16'h0000);
    $display("test pause done");
    report_and_stop();
  end
  // run is about 140 cycles; allow ample margin
  initial
  begin
    #200us;
    fails++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule : pcb_regs_test
`default_nettype wire
